// file: src/mac_cfg.svh
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH
// Notes on behaviour
// - within 1200 ms of power: indicator red, outputs at power-up values
// - after power-up start first measurement, or wait for poll or sync
// - keep power-up outputs and report no distance until first process ends
// - four activation modes: continuous, poll, master, slave; continuous default
// - continuous: repeat at interval, update outputs and store distance each end
// - continuous: answer polls anytime with stored distance, measurement undisturbed
// - poll mode: a poll starts one process, then idle until next poll
// - poll mode: reply carries previous result, not the triggered one
// - poll during a running process: finish it, then start another
// - master serial sends only sync commands, never distance data
// - master period is phase count times measurement interval
// - group has one master with phase count; each slave holds its phase
// - slave starts on sync command, delayed by its phase 1 to 5
// - slave without sync: stop, flash red/green, after delay no-sync outputs
// - both sync roles keep driving outputs from their measurements
// - sync modes switch serial to multi-drop differential electrical mode
// - default serial role is addressed Modbus slave
// - optional one-way streaming of each measurement without requests
// - controller requests served in every mode except synchronization

`define MAC_CLK_HZ       40000000
`define MAC_TICK_MS      1
`define MAC_TICK_CYC     (`MAC_CLK_HZ / 1000 * `MAC_TICK_MS)
`define MAC_PWRUP_MS     1200
`define MAC_PWRUP_CYC    (`MAC_CLK_HZ / 1000 * `MAC_PWRUP_MS)
`define MAC_INIT_CYC     16
`define MAC_DIST_W       16
`define MAC_TMR_W        24
`define MAC_BLINK_BIT    8
`define MAC_HSIZE_WORD   3'h2

`define MAC_OFF_CTRL     8'h00
`define MAC_OFF_INTV     8'h04
`define MAC_OFF_NSDLY    8'h08
`define MAC_OFF_SYNCTO   8'h0c
`define MAC_OFF_PWRUP    8'h10
`define MAC_OFF_NSOUT    8'h14
`define MAC_OFF_STATUS   8'h18
`define MAC_OFF_DIST     8'h1c
`define MAC_OFF_ISTAT    8'h20
`define MAC_OFF_IMASK    8'h24

`define MAC_CTRL_MODE    0
`define MAC_CTRL_STREAM  2
`define MAC_CTRL_PHASE   4
`define MAC_MODE_RST     2'h0
`define MAC_STREAM_RST   1'b0
`define MAC_PHASE_RST    3'h2
`define MAC_INTV_RST     24'h000032
`define MAC_NSDLY_RST    24'h0003e8
`define MAC_SYNCTO_RST   24'h0001f4
`define MAC_PWRUP_RST    16'h0000
`define MAC_NSOUT_RST    16'h0000

`define MAC_IRQ_N        4
`define MAC_IRQ_DONE     0
`define MAC_IRQ_OVR      1
`define MAC_IRQ_LOST     2
`define MAC_IRQ_NOSYNC   3
`endif

// file: src/mac_pkg.sv
package mac_pkg;
	typedef enum logic [1:0] {
		MAC_CONT   = 2'h0,
		MAC_POLL   = 2'h1,
		MAC_MASTER = 2'h2,
		MAC_SLAVE  = 2'h3
	} mac_mode_t;
	typedef enum logic [2:0] {
		ST_INIT = 3'h1,
		ST_IDLE = 3'h2,
		ST_MEAS = 3'h4
	} mac_state_t;
endpackage : mac_pkg

// file: src/mac_timer.sv
`timescale 1ns/1ps
module mac_timer #(
	parameter int W = 24
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	output logic              armed,
	output logic              expired
);
	logic [W-1:0] cnt_r;
	logic         armed_r;
	logic         exp_r;
	wire          atZero = (cnt_r == '0);
	wire          fire   = armed_r & atZero & ~load;

	if (W < 1) begin : g_bad
		$error("mac_timer: W must be at least 1");
	end

	// counts ms ticks down; one pulse on reaching zero, then disarms
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r   <= '0;
			armed_r <= 1'b0;
			exp_r   <= 1'b0;
		end else begin
			exp_r <= fire;
			if (load) begin
				cnt_r   <= loadVal;
				armed_r <= 1'b1;
			end else if (fire) begin
				armed_r <= 1'b0;
			end else if (armed_r & tick) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	assign armed   = armed_r;
	assign expired = exp_r;
endmodule : mac_timer

// file: src/mac_top.sv
`timescale 1ns/1ps
`include "mac_cfg.svh"
module mac_top #(
	parameter int TICK_CYC     = `MAC_TICK_CYC,
	parameter int INIT_CYC     = `MAC_INIT_CYC,
	parameter int DW           = `MAC_DIST_W,
	parameter bit NATIVE_RS485 = 1'b0
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic               hresp,
	input  wire logic          measDone,
	input  wire logic [DW-1:0] measDist,
	input  wire logic          measHit,
	output logic               measStart,
	input  wire logic          pollReq,
	input  wire logic          syncCmdIn,
	output logic               replyValid,
	output logic      [DW-1:0] replyDist,
	output logic               streamValid,
	output logic      [DW-1:0] streamDist,
	output logic               syncCmdOut,
	output logic               rs485Sel,
	output logic               modbusEn,
	output logic      [DW-1:0] outWord,
	output logic               tgtRed,
	output logic               tgtGreen,
	output logic               irq
);
	localparam int TKW = $clog2(TICK_CYC);
	localparam int IW  = $clog2(INIT_CYC + 1);
	localparam int TW  = `MAC_TMR_W;
	localparam int NI  = `MAC_IRQ_N;

	if (TICK_CYC < 2 || INIT_CYC < 1 || INIT_CYC > `MAC_PWRUP_CYC ||
		DW < 1 || DW > 32) begin : g_bad
		$error("mac_top: parameter out of range");
	end

	function automatic logic isSyncMode(input mac_pkg::mac_mode_t m);
		return (m == mac_pkg::MAC_MASTER) || (m == mac_pkg::MAC_SLAVE);
	endfunction : isSyncMode

	mac_pkg::mac_mode_t  mode_r;
	mac_pkg::mac_state_t state_r;
	mac_pkg::mac_state_t state_nxt;
	logic                stream_r;
	logic [2:0]          phase_r;
	logic [TW-1:0]       interval_r;
	logic [TW-1:0]       nsDly_r;
	logic [TW-1:0]       syncTo_r;
	logic [DW-1:0]       pwrupOut_r;
	logic [DW-1:0]       nsOut_r;
	logic [DW-1:0]       distR_r;
	logic [DW-1:0]       outWord_r;
	logic [DW-1:0]       replyDist_r;
	logic [DW-1:0]       streamDist_r;
	logic [NI-1:0]       intStat_r;
	logic [NI-1:0]       intMask_r;
	logic [TKW-1:0]      tickCnt_r;
	logic [`MAC_BLINK_BIT:0] blinkCnt_r;
	logic [IW-1:0]       initCnt_r;
	logic [7:0]          wrAddr_r;
	logic [31:0]         hrdata_r;
	logic                wrPend_r;
	logic                hreadyout_r;
	logic                tick_r;
	logic                pend_r;
	logic                firstDone_r;
	logic                hit_r;
	logic                syncLost_r;
	logic                noSync_r;
	logic                measStart_r;
	logic                replyValid_r;
	logic                streamValid_r;
	logic                syncCmdOut_r;
	logic                rs485Sel_r;
	logic                modbusEn_r;
	logic                tgtRed_r;
	logic                tgtGreen_r;
	logic                irq_r;
	logic                intvArmed;
	logic                intvExp;
	logic                phExp;
	logic                toArmed;
	logic                toExp;
	logic                nsExp;

	// bus slave: zero wait states, always OKAY
	wire        addrPhase = hsel & htrans[1] & hready;
	wire        wordXfer  = (hsize == `MAC_HSIZE_WORD);
	wire [7:0]  rdAddr    = haddr[7:0];
	wire        wrCtrl    = wrPend_r & (wrAddr_r == `MAC_OFF_CTRL);
	wire        wrIntv    = wrPend_r & (wrAddr_r == `MAC_OFF_INTV);
	wire        wrNsDly   = wrPend_r & (wrAddr_r == `MAC_OFF_NSDLY);
	wire        wrSyncTo  = wrPend_r & (wrAddr_r == `MAC_OFF_SYNCTO);
	wire        wrPwrup   = wrPend_r & (wrAddr_r == `MAC_OFF_PWRUP);
	wire        wrNsOut   = wrPend_r & (wrAddr_r == `MAC_OFF_NSOUT);
	wire        wrIstat   = wrPend_r & (wrAddr_r == `MAC_OFF_ISTAT);
	wire        wrImask   = wrPend_r & (wrAddr_r == `MAC_OFF_IMASK);

	// mode decode
	wire isCont   = (mode_r == mac_pkg::MAC_CONT);
	wire isPoll   = (mode_r == mac_pkg::MAC_POLL);
	wire isMaster = (mode_r == mac_pkg::MAC_MASTER);
	wire isSlave  = (mode_r == mac_pkg::MAC_SLAVE);
	wire isSync   = isSyncMode(mode_r);
	wire stInit   = (state_r == mac_pkg::ST_INIT);
	wire stIdle   = (state_r == mac_pkg::ST_IDLE);
	wire stMeas   = (state_r == mac_pkg::ST_MEAS);

	// phase field: master phase count or slave phase, clamped to 1..5
	wire [2:0] phSel = (phase_r == 3'h0) ? 3'h1 :
		(phase_r > 3'h5) ? 3'h5 : phase_r;

	wire tickWrap = (tickCnt_r == TKW'(TICK_CYC - 1));
	wire blink    = blinkCnt_r[`MAC_BLINK_BIT];
	wire initEnd  = stInit & (initCnt_r == IW'(INIT_CYC - 1));
	wire doneOk   = stMeas & measDone;

	// timer control
	wire          freeRun  = (isCont | isMaster) & ~stInit;
	wire          intvLoad = freeRun & ~intvArmed;
	wire [TW-1:0] intvVal  = isMaster ? TW'(interval_r * phSel) :
		interval_r;
	wire          phLoad   = isSlave & syncCmdIn;
	wire [TW-1:0] phVal    = TW'(interval_r * (phSel - 3'h1));
	wire          toLoad   = isSlave & ~stInit &
		(syncCmdIn | (~toArmed & ~syncLost_r & ~toExp));
	wire          nsLoad   = isSlave & toExp & ~syncLost_r;

	// activation
	wire stopMeas = isSlave & syncLost_r;
	wire measEvt  = (freeRun & intvExp) |
		(isPoll & pollReq & ~stInit) |
		(isSlave & phExp & ~syncLost_r) |
		(initEnd & (isCont | isMaster));
	wire startNow = stIdle & pend_r & ~stopMeas;
	// a trigger during a running process is kept until it ends
	wire pend_nxt = measEvt | (pend_r & ~startNow & ~stopMeas);

	wire syncLost_nxt = isSlave &
		(toExp | (syncLost_r & ~syncCmdIn));
	wire noSync_nxt   = isSlave & ~syncCmdIn &
		(noSync_r | (nsExp & syncLost_r));

	// output value: power-up until first result, no-sync value once the no-sync delay after loss expires
	wire [DW-1:0] outWord_nxt = noSync_r ? nsOut_r :
		doneOk ? measDist :
		firstDone_r ? distR_r : pwrupOut_r;
	wire tgtRed_nxt   = syncLost_r ? blink : ~(firstDone_r & hit_r);
	wire tgtGreen_nxt = syncLost_r ? ~blink : (firstDone_r & hit_r);

	// distance replies only outside sync modes and after a result exists
	wire replyNow = pollReq & ~isSync & ~stInit & firstDone_r;
	wire streamNow = doneOk & stream_r & ~isSync;

	wire [NI-1:0] intEvt;
	assign intEvt[`MAC_IRQ_DONE]   = doneOk;
	assign intEvt[`MAC_IRQ_OVR]    = isPoll & pollReq & stMeas;
	assign intEvt[`MAC_IRQ_LOST]   = nsLoad;
	assign intEvt[`MAC_IRQ_NOSYNC] = noSync_nxt & ~noSync_r;
	wire [NI-1:0] w1c = wrIstat ? hwdata[NI-1:0] : '0;
	wire [NI-1:0] intStat_nxt = intEvt | (intStat_r & ~w1c);

	wire [31:0] ctrlWord = {25'h0, phase_r, 1'b0, stream_r, mode_r};
	wire [31:0] statWord = {26'h0, noSync_r, syncLost_r, firstDone_r,
		pend_r, stMeas, stIdle};
	wire [31:0] rdData =
		(rdAddr == `MAC_OFF_CTRL)   ? ctrlWord :
		(rdAddr == `MAC_OFF_INTV)   ? 32'(interval_r) :
		(rdAddr == `MAC_OFF_NSDLY)  ? 32'(nsDly_r) :
		(rdAddr == `MAC_OFF_SYNCTO) ? 32'(syncTo_r) :
		(rdAddr == `MAC_OFF_PWRUP)  ? 32'(pwrupOut_r) :
		(rdAddr == `MAC_OFF_NSOUT)  ? 32'(nsOut_r) :
		(rdAddr == `MAC_OFF_STATUS) ? statWord :
		(rdAddr == `MAC_OFF_DIST)   ? 32'(distR_r) :
		(rdAddr == `MAC_OFF_ISTAT)  ? 32'(intStat_r) :
		(rdAddr == `MAC_OFF_IMASK)  ? 32'(intMask_r) : 32'h0;

	mac_timer #(.W(TW)) u_intv (
		.clk     (clk),
		.reset   (reset),
		.tick    (tick_r),
		.load    (intvLoad),
		.loadVal (intvVal),
		.armed   (intvArmed),
		.expired (intvExp)
	);
	mac_timer #(.W(TW)) u_phase (
		.clk     (clk),
		.reset   (reset),
		.tick    (tick_r),
		.load    (phLoad),
		.loadVal (phVal),
		.armed   (),
		.expired (phExp)
	);
	mac_timer #(.W(TW)) u_synto (
		.clk     (clk),
		.reset   (reset),
		.tick    (tick_r),
		.load    (toLoad),
		.loadVal (syncTo_r),
		.armed   (toArmed),
		.expired (toExp)
	);
	mac_timer #(.W(TW)) u_nsdly (
		.clk     (clk),
		.reset   (reset),
		.tick    (tick_r),
		.load    (nsLoad),
		.loadVal (nsDly_r),
		.armed   (),
		.expired (nsExp)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mac_pkg::ST_INIT: if (initEnd) state_nxt = mac_pkg::ST_IDLE;
			mac_pkg::ST_IDLE: if (startNow) state_nxt = mac_pkg::ST_MEAS;
			mac_pkg::ST_MEAS: if (measDone) state_nxt = mac_pkg::ST_IDLE;
			default: state_nxt = mac_pkg::ST_INIT;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hreadyout_r <= 1'b1;
			wrPend_r    <= 1'b0;
			wrAddr_r    <= 8'h00;
			hrdata_r    <= 32'h0;
		end else begin
			wrPend_r <= addrPhase & hwrite & wordXfer;
			wrAddr_r <= haddr[7:0];
			hrdata_r <= (addrPhase & ~hwrite) ? rdData : 32'h0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_r     <= mac_pkg::mac_mode_t'(`MAC_MODE_RST);
			stream_r   <= `MAC_STREAM_RST;
			phase_r    <= `MAC_PHASE_RST;
			interval_r <= `MAC_INTV_RST;
			nsDly_r    <= `MAC_NSDLY_RST;
			syncTo_r   <= `MAC_SYNCTO_RST;
			pwrupOut_r <= DW'(`MAC_PWRUP_RST);
			nsOut_r    <= DW'(`MAC_NSOUT_RST);
			intMask_r  <= '0;
		end else begin
			if (wrCtrl) begin
				mode_r   <= mac_pkg::mac_mode_t'(hwdata[`MAC_CTRL_MODE +: 2]);
				stream_r <= hwdata[`MAC_CTRL_STREAM];
				phase_r  <= hwdata[`MAC_CTRL_PHASE +: 3];
			end
			if (wrIntv) interval_r <= hwdata[TW-1:0];
			if (wrNsDly) nsDly_r <= hwdata[TW-1:0];
			if (wrSyncTo) syncTo_r <= hwdata[TW-1:0];
			if (wrPwrup) pwrupOut_r <= hwdata[DW-1:0];
			if (wrNsOut) nsOut_r <= hwdata[DW-1:0];
			if (wrImask) intMask_r <= hwdata[NI-1:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tickCnt_r  <= '0;
			tick_r     <= 1'b0;
			blinkCnt_r <= '0;
			initCnt_r  <= '0;
		end else begin
			tickCnt_r <= tickWrap ? '0 : tickCnt_r + 1'b1;
			tick_r    <= tickWrap;
			if (tick_r) blinkCnt_r <= blinkCnt_r + 1'b1;
			if (stInit) initCnt_r <= initCnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r     <= mac_pkg::ST_INIT;
			pend_r      <= 1'b0;
			measStart_r <= 1'b0;
			firstDone_r <= 1'b0;
			hit_r       <= 1'b0;
			distR_r     <= '0;
			syncLost_r  <= 1'b0;
			noSync_r    <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			pend_r      <= pend_nxt;
			measStart_r <= startNow;
			syncLost_r  <= syncLost_nxt;
			noSync_r    <= noSync_nxt;
			if (doneOk) begin
				firstDone_r <= 1'b1;
				hit_r       <= measHit;
				distR_r     <= measDist;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			outWord_r     <= DW'(`MAC_PWRUP_RST);
			tgtRed_r      <= 1'b1;
			tgtGreen_r    <= 1'b0;
			replyValid_r  <= 1'b0;
			replyDist_r   <= '0;
			streamValid_r <= 1'b0;
			streamDist_r  <= '0;
			syncCmdOut_r  <= 1'b0;
			rs485Sel_r    <= NATIVE_RS485;
			modbusEn_r    <= 1'b1;
			intStat_r     <= '0;
			irq_r         <= 1'b0;
		end else begin
			outWord_r     <= outWord_nxt;
			tgtRed_r      <= tgtRed_nxt;
			tgtGreen_r    <= tgtGreen_nxt;
			replyValid_r  <= replyNow;
			if (pollReq) replyDist_r <= distR_r;
			streamValid_r <= streamNow;
			if (doneOk) streamDist_r <= measDist;
			syncCmdOut_r  <= isMaster & intvExp;
			rs485Sel_r    <= isSync | NATIVE_RS485;
			modbusEn_r    <= ~isSync;
			intStat_r     <= intStat_nxt;
			irq_r         <= |(intStat_nxt & intMask_r);
		end
	end

	assign hrdata      = hrdata_r;
	assign hreadyout   = hreadyout_r;
	assign hresp       = 1'b0 & hreadyout_r;
	assign measStart   = measStart_r;
	assign replyValid  = replyValid_r;
	assign replyDist   = replyDist_r;
	assign streamValid = streamValid_r;
	assign streamDist  = streamDist_r;
	assign syncCmdOut  = syncCmdOut_r;
	assign rs485Sel    = rs485Sel_r;
	assign modbusEn    = modbusEn_r;
	assign outWord     = outWord_r;
	assign tgtRed      = tgtRed_r;
	assign tgtGreen    = tgtGreen_r;
	assign irq         = irq_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_pwrup_red;
		stInit |-> tgtRed_r && !tgtGreen_r;
	endproperty
	a_pwrup_red: assert property (p_pwrup_red)
		else $error("indicator not red during power-up");

	property p_first_start;
		initEnd && (isCont || isMaster) |-> ##2 measStart_r;
	endproperty
	a_first_start: assert property (p_first_start)
		else $error("first measurement not started after power-up");

	property p_hold_pwrup;
		!$past(firstDone_r) && !$past(doneOk) && !$past(noSync_r)
			|-> outWord_r == $past(pwrupOut_r);
	endproperty
	a_hold_pwrup: assert property (p_hold_pwrup)
		else $error("output left power-up value too early");

	property p_no_early_reply;
		replyValid_r |-> $past(firstDone_r);
	endproperty
	a_no_early_reply: assert property (p_no_early_reply)
		else $error("distance reported before first result");

	property p_store;
		doneOk && !noSync_r |=> distR_r == $past(measDist) &&
			outWord_r == $past(measDist);
	endproperty
	a_store: assert property (p_store)
		else $error("result not stored or output not updated");

	property p_poll_start;
		isPoll && stIdle && !pend_r && pollReq ##1 isPoll
			|-> ##1 measStart_r;
	endproperty
	a_poll_start: assert property (p_poll_start)
		else $error("poll did not start a measurement");

	property p_reply_prev;
		replyNow |=> replyValid_r && replyDist_r == $past(distR_r);
	endproperty
	a_reply_prev: assert property (p_reply_prev)
		else $error("poll reply not the previous result");

	property p_poll_during_meas;
		isPoll && doneOk && pend_r ##1 isPoll |-> ##1 measStart_r;
	endproperty
	a_poll_during_meas: assert property (p_poll_during_meas)
		else $error("pending poll not served after completion");

	property p_sync_quiet;
		isSync && $past(isSync) |-> !replyValid_r && !streamValid_r;
	endproperty
	a_sync_quiet: assert property (p_sync_quiet)
		else $error("distance sent in a sync mode");

	property p_slave_phase1;
		isSlave && phSel == 3'h1 && syncCmdIn && stIdle && !pend_r &&
			!syncLost_r |-> ##[3:5] measStart_r;
	endproperty
	a_slave_phase1: assert property (p_slave_phase1)
		else $error("slave phase 1 did not start on sync");

	property p_lost_stop;
		syncLost_r && $past(syncLost_r) |-> !measStart_r && !pend_r;
	endproperty
	a_lost_stop: assert property (p_lost_stop)
		else $error("slave measured without sync");

	// the two colours alternate with the slow blink counter, not a fixed state
	property p_lost_flash;
		syncLost_r |=> tgtRed_r == $past(blink) &&
			tgtGreen_r == !$past(blink);
	endproperty
	a_lost_flash: assert property (p_lost_flash)
		else $error("indicator not flashing while sync lost");

	property p_rs485;
		$past(isSync) |-> rs485Sel_r && !modbusEn_r;
	endproperty
	a_rs485: assert property (p_rs485)
		else $error("sync mode without multi-drop interface");

	property p_stream;
		streamNow |=> streamValid_r && streamDist_r == $past(measDist);
	endproperty
	a_stream: assert property (p_stream)
		else $error("measurement not streamed");

	c_poll_overrun: cover property (isPoll && stMeas && pollReq);
	c_nosync: cover property ($rose(noSync_r));
	c_master_cmd: cover property (syncCmdOut_r ##[1:8] measStart_r);
	c_stream: cover property (streamValid_r);
endmodule : mac_top

// file: verification/mac_far_model.sv
`timescale 1ns/1ps
module mac_far_model #(
	parameter int DLY = 40,
	parameter int SP  = 30
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        measStart,
	input  wire logic        syncEn,
	output logic             measDone,
	output logic      [15:0] measDist,
	output logic             measHit,
	output logic             syncCmdIn,
	output logic      [15:0] lastDist
);
	int busyCnt;
	int syncCnt;
	// engine: result DLY cycles after start, distance toggles when not valid
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busyCnt  <= 0;
			measDone <= 1'b0;
			measHit  <= 1'b0;
			measDist <= 16'h0000;
			lastDist <= 16'h0100;
		end else begin
			measDone <= (busyCnt == 1);
			measHit  <= (busyCnt == 1);
			if (measStart)
				busyCnt <= DLY;
			else if (busyCnt > 0)
				busyCnt <= busyCnt - 1;
			if (busyCnt == 1) begin
				measDist <= lastDist + 16'h0011;
				lastDist <= lastDist + 16'h0011;
			end else
				measDist <= ~measDist;
		end
	end
	// group master peer: one sync command every SP cycles
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncCnt   <= 0;
			syncCmdIn <= 1'b0;
		end else begin
			syncCnt   <= (syncEn && syncCnt < SP - 1) ? syncCnt + 1 : 0;
			syncCmdIn <= syncEn && (syncCnt == SP - 1);
		end
	end
endmodule : mac_far_model

// file: verification/tb_measurement_activation_control.sv
`timescale 1ns/1ps
module tb_measurement_activation_control;
	logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic measDone, measHit, measStart, pollReq, syncCmdIn, syncEn;
	logic replyValid, streamValid, syncCmdOut, rs485Sel, modbusEn;
	logic tgtRed, tgtGreen, rv;
	logic [15:0] measDist, replyDist, streamDist, outWord, lastDist, prev, rd;
	int error_cnt, total_checks, n;
	assign hready = hreadyout;
	mac_top #(.TICK_CYC(4), .INIT_CYC(4)) u_dut (.clk(clk), .reset(reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .measDone(measDone),
		.measDist(measDist), .measHit(measHit), .measStart(measStart),
		.pollReq(pollReq), .syncCmdIn(syncCmdIn), .replyValid(replyValid),
		.replyDist(replyDist), .streamValid(streamValid),
		.streamDist(streamDist), .syncCmdOut(syncCmdOut),
		.rs485Sel(rs485Sel), .modbusEn(modbusEn), .outWord(outWord),
		.tgtRed(tgtRed), .tgtGreen(tgtGreen), .irq(irq));
	mac_far_model u_far (.clk(clk), .reset(reset), .measStart(measStart),
		.syncEn(syncEn), .measDone(measDone), .measDist(measDist),
		.measHit(measHit), .syncCmdIn(syncCmdIn), .lastDist(lastDist));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, ex, got);
		end
	endtask : chk
	task rdy;
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (k >= 50) begin
			chk("hready", 1, 0);
			tally_and_finish;
		end
	endtask : rdy
	task wr(input logic [31:0] a, input logic [31:0] d);
		haddr  <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
	endtask : wr
	task rd_reg(input logic [31:0] a, output logic [31:0] d);
		haddr  <= a;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		rdy;
		htrans <= 2'h0;
		rdy;
		d = hrdata;
	endtask : rd_reg
	// 0 start, 1 done, 2 sync out, 3 sync in; n counts edges waited
	task wait_sig(input int w, output int k);
		logic s;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
			s = (w == 0) ? measStart : (w == 1) ? measDone :
				(w == 2) ? syncCmdOut : syncCmdIn;
		end while (s !== 1'b1 && k < 3000);
		if (k >= 3000) begin
			chk("wait", 1, 0);
			tally_and_finish;
		end
	endtask : wait_sig
	task poll(output logic v, output logic [15:0] d);
		@(posedge clk);
		pollReq <= 1'b1;
		@(posedge clk);
		pollReq <= 1'b0;
		#1;
		v = replyValid;
		d = replyDist;
	endtask : poll
	initial begin
		{hsel, hwrite, pollReq, syncEn} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		error_cnt = 0;
		total_checks = 0;
		reset = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		hsel <= 1'b1;
		@(posedge clk);
		#1;
		chk("tgtRed", 1, tgtRed);
		chk("modbusEn", 1, modbusEn);
		chk("hresp", 0, hresp);
		wait_sig(0, n);
		poll(rv, rd);
		chk("early reply", 0, rv);
		chk("early out", 0, outWord);
		rd_reg(32'h00, rdv);
		chk("ctrl", 32'h20, rdv);
		rd_reg(32'h04, rdv);
		chk("intv", 32'h32, rdv);
		rd_reg(32'h30, rdv);
		chk("unmapped", 0, rdv);
		wait_sig(1, n);
		@(posedge clk);
		#1;
		chk("out cont", {16'h0, lastDist}, outWord);
		poll(rv, rd);
		chk("reply cont", {16'h1, lastDist}, {15'h0, rv, rd});
		chk("tgtGreen", 1, tgtGreen);
		wr(32'h24, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq on", 1, irq);
		wr(32'h20, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq clr", 0, irq);
		$display("continuous test done");
		wr(32'h00, 32'h25);
		prev = lastDist;
		poll(rv, rd);
		chk("reply prev", {16'h1, prev}, {15'h0, rv, rd});
		wait_sig(0, n);
		chk("poll start", 1, n);
		poll(rv, rd);
		chk("busy reply", {16'h1, prev}, {15'h0, rv, rd});
		wait_sig(1, n);
		wait_sig(0, n);
		chk("pend start", 2, n);
		wait_sig(1, n);
		@(posedge clk);
		#1;
		chk("stream", {16'h1, lastDist}, {15'h0, streamValid, streamDist});
		n = 0;
		repeat (60) begin
			@(posedge clk);
			#1;
			n += int'(measStart);
		end
		chk("idle", 0, n);
		$display("poll test done");
		wr(32'h00, 32'h26);
		wait_sig(2, n);
		chk("rs485", 1, rs485Sel);
		chk("modbus off", 0, modbusEn);
		wait_sig(2, n);
		chk("sync period", 1, 32'(n >= 400 && n <= 404));
		poll(rv, rd);
		chk("master reply", 0, rv);
		wait_sig(1, n);
		@(posedge clk);
		#1;
		chk("master out", {16'h0, lastDist}, outWord);
		chk("master stream", 0, streamValid);
		$display("master test done");
		wr(32'h0c, 32'ha);
		wr(32'h08, 32'h5);
		wr(32'h14, 32'h55);
		wr(32'h00, 32'h13);
		syncEn <= 1'b1;
		wait_sig(3, n);
		wait_sig(0, n);
		chk("slave delay", 4, n);
		wait_sig(1, n);
		syncEn <= 1'b0;
		repeat (120) @(posedge clk);
		chk("nosync out", 32'h55, outWord);
		rd_reg(32'h18, rdv);
		chk("lost bits", 3, rdv[5:4]);
		syncEn <= 1'b1;
		wait_sig(3, n);
		repeat (3) @(posedge clk);
		chk("sync back", {16'h0, lastDist}, outWord);
		$display("slave test done");
		tally_and_finish;
	end
endmodule : tb_measurement_activation_control
